// ---- lsdc_map.vh ----
// Register offsets, fields and reset values of the loop station register bank
// Assumes byte addressing on a 32-bit AXI4-Lite bus
`ifndef LSDC_MAP_VH
`define LSDC_MAP_VH
`define LSDC_ADDR_W      12
`define LSDC_OFF_CTRL    12'h000
`define LSDC_OFF_SCAN    12'h004
`define LSDC_OFF_FILT    12'h008
`define LSDC_OFF_COIL    12'h00c
`define LSDC_OFF_TYPE    12'h010
`define LSDC_OFF_CONN    12'h014
`define LSDC_OFF_AFLT    12'h018
`define LSDC_OFF_STAGE   12'h01c
`define LSDC_OFF_LFLT    12'h020
`define LSDC_OFF_TPCT    12'h024
`define LSDC_OFF_TSPD    12'h028
`define LSDC_OFF_BAUD    12'h02c
`define LSDC_OFF_SWVER   12'h030
`define LSDC_OFF_STAT    12'h034
`define LSDC_OFF_ALARM   12'h038
`define LSDC_OFF_FAIL    12'h100
`define LSDC_OFF_MAP     12'h200
`define LSDC_TBL_MASK    12'hf00
`define LSDC_CTRL_ESD_EN 0
`define LSDC_CTRL_LINK   1
`define LSDC_COIL_ACC    0
`define LSDC_COIL_XFER   1
`define LSDC_COIL_ESD    2
`define LSDC_COIL_RECFG  3
`define LSDC_STAT_PASSV  0
`define LSDC_STAT_PRIM   1
`define LSDC_RST_CTRL    2'h0
`define LSDC_RST_SCAN    8'hff
`define LSDC_RST_FILT    16'h0000
`define LSDC_RESP_OKAY   2'h0
`define LSDC_RESP_SLVERR 2'h2
`endif

// ---- lsdc_unit_mem.v ----
// Per field unit failure counters and loop position map
// Assumes event and map strobes come from loop logic on clk
`timescale 1ns/1ns
module lsdc_unit_mem #(
  parameter AW = 6
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          fail_evt,
  input  wire [AW-1:0] fail_unit,
  input  wire          map_we,
  input  wire [AW-1:0] map_pos,
  input  wire [7:0]    map_unit,
  input  wire [AW-1:0] cnt_idx,
  output wire [7:0]    cnt_q,
  input  wire [AW-1:0] map_idx,
  output wire [7:0]    map_q
);
  localparam N = 1 << AW;
  reg [7:0] cnt_r [0:N-1];
  reg [7:0] map_r [0:N-1];
  integer i;

  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < N; i = i + 1) begin
        cnt_r[i] <= 8'h00;
        map_r[i] <= 8'h00;
      end
    end else begin
      if (fail_evt)
        cnt_r[fail_unit] <= cnt_r[fail_unit] + 8'h01; // Wraps to zero
      if (map_we)
        map_r[map_pos] <= map_unit;
    end
  end

  assign cnt_q = cnt_r[cnt_idx];
  assign map_q = map_r[map_idx];
endmodule

// ---- lsdc_alarm_img.v ----
// One port's latched alarm image with read and accept tracking
// Assumes rd and acc are one-cycle pulses on clk
`timescale 1ns/1ns
module lsdc_alarm_img #(
  parameter NA = 8
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire [NA-1:0] src,
  input  wire          rd,
  input  wire          acc,
  output wire [NA-1:0] img
);
  reg  [NA-1:0] lat_r;
  reg  [NA-1:0] seen_r;
  reg  [NA-1:0] ack_r;
  wire [NA-1:0] clr;

  // Clear only read, accepted and returned to normal
  assign clr = ack_r & ~src;

  always @(posedge clk) begin
    if (!rst_b) begin
      lat_r  <= {NA{1'b0}};
      seen_r <= {NA{1'b0}};
      ack_r  <= {NA{1'b0}};
    end else begin
      lat_r  <= src | (lat_r & ~clr); // Latch, set wins
      seen_r <= (rd ? (seen_r | lat_r) : seen_r) & ~clr;
      ack_r  <= (acc ? (ack_r | seen_r) : ack_r) & ~clr; // Earlier read only
    end
  end

  assign img = lat_r;
endmodule

// ---- lsdc_top.v ----
// Loop station system data registers and command coils on AXI4-Lite
// Assumes status, strobes and alarm sources come from loop logic on clk
//
// Summary of operation
// - One 8-bit failure counter per unit, retries counted, wraps to zero.
// - Map table lists unit addresses in physical loop order.
// - One register reports the highest unit address polling searches.
// - Connected counts per loop port; a split locates a cable fault.
// - Address fault register holds position and address of faulty unit.
// - Configuration progress register shows a value per configuration stage.
// - Loop fault register holds blocking faults, reconfiguration code, fault type.
// - Last loop test result held as a hex percentage.
// - Speed of last loop test held in a register.
// - Loop baud rate exposed as an encoded number.
// - Loop module software version exposed from its program memory.
// - Command filter timeout and device type number in registers.
// - Alarm accept accepts only alarms read in an earlier transaction.
// - Each host port and display keeps its own accept tracking and image.
// - Alarm clears only if read, accepted and condition back to normal.
// - Linked alarms: one accept acts on every image.
// - Transfer coil swaps primary and standby control.
// - Passive standby obeys only the transfer coil, ignores other writes.
// - Shutdown coil broadcasts to all units only when enabled in setup.
// - Reconfigure coil makes the loop reconfigure.
// - Alarm bits latch until read, accepted and source normal.
// - Writes to any logical station act on all; host uses base address.
`timescale 1ns/1ns
`include "lsdc_map.vh"
module lsdc_top #(
  parameter        AW        = 6,
  parameter        NALM      = 8,
  parameter        NPORT     = 4,
  parameter [15:0] TYPE_NUM  = 16'h0001 // Arbitrary type number
) (
  input  wire                  clk,
  input  wire                  rst_b,
  input  wire [11:0]           s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  output wire [1:0]            s_axi_bresp,
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [11:0]           s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output wire [31:0]           s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  input  wire                  fail_evt,
  input  wire [AW-1:0]         fail_unit,
  input  wire                  map_we,
  input  wire [AW-1:0]         map_pos,
  input  wire [7:0]            map_unit,
  input  wire [7:0]            conn_port_a,
  input  wire [7:0]            conn_port_b,
  input  wire [7:0]            fault_pos,
  input  wire [7:0]            fault_unit,
  input  wire [7:0]            cfg_stage,
  input  wire [15:0]           loop_fault,
  input  wire [7:0]            test_pct,
  input  wire [7:0]            test_speed,
  input  wire [7:0]            baud_code,
  input  wire [15:0]           loop_sw_ver,
  input  wire                  standby_passive,
  input  wire                  is_primary,
  input  wire [NALM-1:0]       alarm_src,
  input  wire [NPORT-1:1]      ext_rd,
  input  wire [NPORT-1:1]      ext_acc,
  output wire [NPORT*NALM-1:0] alarm_img,
  output wire [7:0]            scan_limit,
  output wire [15:0]           filt_timeout,
  output wire                  esd_enable,
  output reg                   xfer_pulse,
  output reg                   esd_pulse,
  output reg                   recfg_pulse
);
  reg         aw_hold_r;
  reg  [11:0] awaddr_r;
  reg         w_hold_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;
  reg  [1:0]  ctrl_r;
  reg  [7:0]  scan_r;
  reg  [15:0] filt_r;
  reg         acc_bus_r;
  reg         rd_bus_r;
  reg  [31:0] rd_nxt;
  reg         rd_ok;
  reg         wr_ok;
  wire        wr_go;
  wire        rd_go;
  wire [7:0]  cnt_q;
  wire [7:0]  map_q;
  wire [11:0] tbl_off;
  wire [NPORT-1:0] rd_v;
  wire [NPORT-1:0] acc_raw;
  wire [NPORT-1:0] acc_v;
  wire [11:0] tbl_size;
  wire        wsel_ctrl;
  wire        wsel_scan;
  wire        wsel_filt;
  wire        wsel_coil;
  wire        setup_we;
  wire        coil_we;
  wire        coil_acc;
  wire        coil_xfer;
  wire        coil_esd;
  wire        coil_recfg;
  wire        fail_hit;
  wire        map_hit;
  wire        rd_alarm;
  wire        alarm_link;
  wire [15:0] conn_word;
  wire [15:0] aflt_word;
  wire [1:0]  stat_word;

  // Table offset and hits for counters and map
  assign tbl_size = 12'h004 << AW;
  assign tbl_off  = s_axi_araddr - (s_axi_araddr & `LSDC_TBL_MASK);
  assign fail_hit = ((s_axi_araddr & `LSDC_TBL_MASK) == `LSDC_OFF_FAIL) && (tbl_off < tbl_size);
  assign map_hit  = ((s_axi_araddr & `LSDC_TBL_MASK) == `LSDC_OFF_MAP) && (tbl_off < tbl_size);

  // Write channels taken independently, response after both
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign wr_go         = aw_hold_r && w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always @(posedge clk) begin
    if (!rst_b) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 12'h000;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `LSDC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `LSDC_RESP_OKAY : `LSDC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Write decode; one register set serves every logical station
  assign wsel_ctrl = ({awaddr_r[11:2], 2'b00} == `LSDC_OFF_CTRL);
  assign wsel_scan = ({awaddr_r[11:2], 2'b00} == `LSDC_OFF_SCAN);
  assign wsel_filt = ({awaddr_r[11:2], 2'b00} == `LSDC_OFF_FILT);
  assign wsel_coil = ({awaddr_r[11:2], 2'b00} == `LSDC_OFF_COIL);
  assign setup_we  = wr_go && !standby_passive;
  assign coil_we   = wr_go && wsel_coil && wstrb_r[0];

  // Coil bits of the write word
  assign coil_acc   = wdata_r[`LSDC_COIL_ACC];
  assign coil_xfer  = wdata_r[`LSDC_COIL_XFER];
  assign coil_esd   = wdata_r[`LSDC_COIL_ESD];
  assign coil_recfg = wdata_r[`LSDC_COIL_RECFG];

  // Writable address decode
  always @* begin
    case ({awaddr_r[11:2], 2'b00})
      `LSDC_OFF_CTRL: wr_ok = 1'b1;
      `LSDC_OFF_SCAN: wr_ok = 1'b1;
      `LSDC_OFF_FILT: wr_ok = 1'b1;
      `LSDC_OFF_COIL: wr_ok = 1'b1;
      default:        wr_ok = 1'b0;
    endcase
  end

  // Setup registers, writes ignored in passive standby
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= `LSDC_RST_CTRL;
      scan_r <= `LSDC_RST_SCAN;
      filt_r <= `LSDC_RST_FILT;
    end else if (setup_we) begin
      if (wsel_ctrl && wstrb_r[0]) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (wsel_scan && wstrb_r[0]) begin
        scan_r <= wdata_r[7:0];
      end
      if (wsel_filt && wstrb_r[0]) begin
        filt_r[7:0] <= wdata_r[7:0];
      end
      if (wsel_filt && wstrb_r[1]) begin
        filt_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  assign scan_limit   = scan_r;
  assign filt_timeout = filt_r;
  assign esd_enable   = ctrl_r[`LSDC_CTRL_ESD_EN];

  // Coils fire one pulse per energising write
  always @(posedge clk) begin
    if (!rst_b) begin
      xfer_pulse  <= 1'b0;
      esd_pulse   <= 1'b0;
      recfg_pulse <= 1'b0;
      acc_bus_r   <= 1'b0;
    end else begin
      xfer_pulse  <= 1'b0;
      esd_pulse   <= 1'b0;
      recfg_pulse <= 1'b0;
      acc_bus_r   <= 1'b0;
      if (coil_we) begin
        xfer_pulse <= coil_xfer; // Obeyed even when passive
        if (!standby_passive) begin
          acc_bus_r   <= coil_acc;
          esd_pulse   <= coil_esd & ctrl_r[`LSDC_CTRL_ESD_EN];
          recfg_pulse <= coil_recfg;
        end
      end
    end
  end

  // Read channel, data registered on the address handshake
  assign s_axi_arready = !rvalid_r;
  assign rd_go         = s_axi_arvalid && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read words assembled from loop status
  assign rd_alarm      = !standby_passive && ({s_axi_araddr[11:2], 2'b00} == `LSDC_OFF_ALARM);
  assign conn_word     = {conn_port_b, conn_port_a};
  assign aflt_word     = {fault_unit, fault_pos};
  assign stat_word     = {is_primary, standby_passive};

  always @* begin
    rd_nxt = 32'h00000000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `LSDC_OFF_CTRL:  rd_nxt[1:0]  = ctrl_r;
      `LSDC_OFF_SCAN:  rd_nxt[7:0]  = scan_r;
      `LSDC_OFF_FILT:  rd_nxt[15:0] = filt_r;
      `LSDC_OFF_COIL:  rd_nxt       = 32'h00000000;
      `LSDC_OFF_TYPE:  rd_nxt[15:0] = TYPE_NUM;
      `LSDC_OFF_CONN:  rd_nxt[15:0] = conn_word;
      `LSDC_OFF_AFLT:  rd_nxt[15:0] = aflt_word;
      `LSDC_OFF_STAGE: rd_nxt[7:0]  = cfg_stage;
      `LSDC_OFF_LFLT:  rd_nxt[15:0] = loop_fault;
      `LSDC_OFF_TPCT:  rd_nxt[7:0]  = test_pct;
      `LSDC_OFF_TSPD:  rd_nxt[7:0]  = test_speed;
      `LSDC_OFF_BAUD:  rd_nxt[7:0]  = baud_code;
      `LSDC_OFF_SWVER: rd_nxt[15:0] = loop_sw_ver;
      `LSDC_OFF_STAT:  rd_nxt[1:0]  = stat_word;
      `LSDC_OFF_ALARM: rd_nxt[NALM-1:0] = alarm_img[NALM-1:0];
      default: begin
        if (fail_hit)
          rd_nxt[7:0] = cnt_q;
        else if (map_hit)
          rd_nxt[7:0] = map_q;
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `LSDC_RESP_OKAY;
      rd_bus_r <= 1'b0;
    end else begin
      rd_bus_r <= 1'b0;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_nxt;
        rresp_r  <= rd_ok ? `LSDC_RESP_OKAY : `LSDC_RESP_SLVERR;
        rd_bus_r <= rd_alarm;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  lsdc_unit_mem #(
    .AW (AW)
  ) u_mem (
    .clk       (clk),
    .rst_b     (rst_b),
    .fail_evt  (fail_evt),
    .fail_unit (fail_unit),
    .map_we    (map_we),
    .map_pos   (map_pos),
    .map_unit  (map_unit),
    .cnt_idx   (tbl_off[AW+1:2]),
    .cnt_q     (cnt_q),
    .map_idx   (tbl_off[AW+1:2]),
    .map_q     (map_q)
  );

  // Port 0 is this bus; others are serial, network and display ports
  assign rd_v    = {ext_rd, rd_bus_r};
  assign acc_raw = {ext_acc, acc_bus_r};
  assign alarm_link = ctrl_r[`LSDC_CTRL_LINK];
  assign acc_v   = alarm_link ? {NPORT{|acc_raw}} : acc_raw;

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      lsdc_alarm_img #(
        .NA (NALM)
      ) u_img (
        .clk   (clk),
        .rst_b (rst_b),
        .src   (alarm_src),
        .rd    (rd_v[g]),
        .acc   (acc_v[g]),
        .img   (alarm_img[g*NALM +: NALM]) // Independent per port
      );
    end
  endgenerate
endmodule

// ---- lsdc_host.sv ----
// Host side AXI4-Lite master model with write and read tasks
// Assumes the bench calls one task at a time; bready and rready stay high
`timescale 1ns/1ns
module lsdc_host (
  input  logic        clk,
  output logic [11:0] s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  logic aw_hs, w_hs, got;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
  end
  task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge clk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs  = s_axi_wvalid & s_axi_wready;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid & ~aw_hs) | (s_axi_wvalid & ~w_hs));
    do begin
      @(negedge clk);
      got = s_axi_bvalid;
      r   = s_axi_bresp;
      @(posedge clk);
    end while (!got);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      got = s_axi_arready;
      @(posedge clk);
    end while (!got);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      got = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
      @(posedge clk);
    end while (!got);
  endtask
endmodule

// ---- lsdc_checker.sv ----
// Port checker of the loop station register bank
// Assumes binding into lsdc_top, one clk domain with rst_b
`timescale 1ns/1ns
module lsdc_checker #(
  parameter NALM  = 8,
  parameter NPORT = 4
) (
  input logic                  clk,
  input logic                  rst_b,
  input logic                  s_axi_awready,
  input logic                  s_axi_wready,
  input logic [1:0]            s_axi_bresp,
  input logic                  s_axi_bvalid,
  input logic                  s_axi_bready,
  input logic                  s_axi_arvalid,
  input logic                  s_axi_arready,
  input logic [31:0]           s_axi_rdata,
  input logic                  s_axi_rvalid,
  input logic                  s_axi_rready,
  input logic [NALM-1:0]       alarm_src,
  input logic [NPORT*NALM-1:0] alarm_img,
  input logic [7:0]            scan_limit,
  input logic                  esd_enable,
  input logic                  xfer_pulse,
  input logic                  esd_pulse,
  input logic                  recfg_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rst_values: assert property (disable iff (1'b0) !rst_b |=> !s_axi_bvalid && !s_axi_rvalid &&
    scan_limit == 8'hff && !xfer_pulse && !esd_pulse && !recfg_pulse && alarm_img == '0)
    else $error("reset values wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_pulse_single: assert property ((xfer_pulse || esd_pulse || recfg_pulse) |=>
    !xfer_pulse && !esd_pulse && !recfg_pulse) else $error("coil pulse repeated");
  a_coil_answer: assert property (xfer_pulse || recfg_pulse |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("coil pulse without write");
  a_shutdown_gate: assert property (esd_pulse |-> esd_enable && $rose(s_axi_bvalid))
    else $error("shutdown pulse while disabled");
  a_alarm_latch: assert property ($past(rst_b) |->
    (alarm_img & {NPORT{$past(alarm_src)}}) == {NPORT{$past(alarm_src)}}) else $error("alarm not latched");
endmodule
bind lsdc_top lsdc_checker #(.NALM(NALM), .NPORT(NPORT)) u_chk (.*);

// ---- tb_loop_station_data_and_commands.sv ----
// Bench of the loop station register bank: register table, counters and map, setup registers, coils, alarms, passive standby, reset
// Assumes lsdc_top with default parameters, driven by the lsdc_host model
`timescale 1ns/1ns
`include "lsdc_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_loop_station_data_and_commands;
  logic        clk, rst_b, fail_evt, map_we, standby_passive, is_primary, esd_enable;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, xfer_pulse, esd_pulse, recfg_pulse;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, alarm_img;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  fail_unit, map_pos;
  logic [7:0]  map_unit, conn_port_a, conn_port_b, fault_pos, fault_unit, cfg_stage, test_pct, test_speed;
  logic [7:0]  baud_code, alarm_src, scan_limit;
  logic [15:0] loop_fault, loop_sw_ver, filt_timeout;
  logic [3:1]  ext_rd, ext_acc;
  int          err_total = 0, total_checks = 0, xn = 0, en = 0, cn = 0;
  logic [45:0] rows [14] = '{
    {`LSDC_OFF_SCAN, 32'hff, 2'h0}, {`LSDC_OFF_FILT, 32'h0, 2'h0}, {`LSDC_OFF_CTRL, 32'h0, 2'h0},
    {`LSDC_OFF_CONN, 32'h0320, 2'h0}, {`LSDC_OFF_AFLT, 32'h1107, 2'h0}, {`LSDC_OFF_STAGE, 32'h05, 2'h0},
    {`LSDC_OFF_LFLT, 32'hbeef, 2'h0}, {`LSDC_OFF_TPCT, 32'h63, 2'h0}, {`LSDC_OFF_TSPD, 32'h02, 2'h0},
    {`LSDC_OFF_BAUD, 32'h04, 2'h0}, {`LSDC_OFF_SWVER, 32'h0312, 2'h0}, {`LSDC_OFF_TYPE, 32'h1, 2'h0},
    {`LSDC_OFF_STAT, 32'h2, 2'h0}, {12'h040, 32'h0, 2'h2}};
  lsdc_top DUT (.*);
  lsdc_host host (.*);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (xfer_pulse === 1'b1) xn <= xn + 1;
    if (esd_pulse === 1'b1) en <= en + 1;
    if (recfg_pulse === 1'b1) cn <= cn + 1;
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task w(input logic [11:0] a, input logic [31:0] v);
    host.wr(a, v, r);
  endtask
  task ck(input logic [11:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    `CHK({d, r}, {e, 2'h0})
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    #40000;
    err_total++;
    close_out;
  end
  initial begin
    {rst_b, fail_evt, map_we, alarm_src, ext_rd, ext_acc, standby_passive} = '0;
    {fail_unit, map_pos, map_unit, is_primary} = {6'h05, 6'h03, 8'h2a, 1'b1};
    {conn_port_a, conn_port_b, fault_pos, fault_unit, cfg_stage} = {8'h20, 8'h03, 8'h07, 8'h11, 8'h05};
    {loop_fault, test_pct, test_speed, baud_code, loop_sw_ver} = {16'hbeef, 8'h63, 8'h02, 8'h04, 16'h0312};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      host.rd(rows[i][45:34], d, r);
      `CHK({d, r}, rows[i][33:0])
    end
    $display("end register table");
    fail_evt <= 1'b1;
    map_we   <= 1'b1;
    repeat (257) @(posedge clk);
    {fail_evt, map_we} <= 2'b00;
    ck(`LSDC_OFF_FAIL + 12'h014, 32'h1);
    ck(`LSDC_OFF_FAIL + 12'h018, 32'h0);
    ck(`LSDC_OFF_MAP + 12'h00c, 32'h2a);
    w(`LSDC_OFF_SCAN, 32'h10);
    ck(`LSDC_OFF_SCAN, 32'h10);
    `CHK(scan_limit, 8'h10)
    w(`LSDC_OFF_FILT, 32'h1234);
    ck(`LSDC_OFF_FILT, 32'h1234);
    `CHK(filt_timeout, 16'h1234)
    host.wr(`LSDC_OFF_TYPE, 32'h9, r);
    `CHK(r, `LSDC_RESP_SLVERR)
    $display("end setup registers");
    w(`LSDC_OFF_COIL, 32'h4);
    w(`LSDC_OFF_CTRL, 32'h1);
    `CHK(esd_enable, 1'b1)
    w(`LSDC_OFF_COIL, 32'h4);
    w(`LSDC_OFF_COIL, 32'h2);
    w(`LSDC_OFF_COIL, 32'h8);
    settle;
    `CHK({en, xn, cn}, {32'd1, 32'd1, 32'd1})
    ck(`LSDC_OFF_COIL, 32'h0);
    $display("end coils");
    alarm_src <= 8'h01;
    repeat (2) @(posedge clk);
    alarm_src <= 8'h00;
    w(`LSDC_OFF_COIL, 32'h1);
    settle;
    `CHK(alarm_img[0], 1'b1)
    ck(`LSDC_OFF_ALARM, 32'h1);
    ext_rd <= 3'b001;
    @(posedge clk);
    ext_rd <= 3'b000;
    w(`LSDC_OFF_COIL, 32'h1);
    settle;
    `CHK({alarm_img[8], alarm_img[0]}, 2'b10)
    w(`LSDC_OFF_CTRL, 32'h3);
    w(`LSDC_OFF_COIL, 32'h1);
    settle;
    `CHK(alarm_img[8], 1'b0)
    ext_rd <= 3'b010;
    @(posedge clk);
    {ext_rd, ext_acc} <= 6'b000100;
    @(posedge clk);
    ext_acc <= 3'b000;
    settle;
    `CHK({alarm_img[24], alarm_img[16]}, 2'b10)
    $display("end alarms");
    standby_passive <= 1'b1;
    host.wr(`LSDC_OFF_SCAN, 32'h55, r);
    `CHK(r, `LSDC_RESP_OKAY)
    ck(`LSDC_OFF_SCAN, 32'h10);
    ck(`LSDC_OFF_STAT, 32'h3);
    w(`LSDC_OFF_COIL, 32'h8);
    w(`LSDC_OFF_COIL, 32'h2);
    settle;
    `CHK({xn, cn}, {32'd2, 32'd1})
    $display("end passive standby");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    ck(`LSDC_OFF_FAIL + 12'h014, 32'h0);
    `CHK({scan_limit, filt_timeout, esd_enable, alarm_img}, {8'hff, 16'h0000, 1'b0, 32'h0})
    $display("end reset");
    close_out;
  end
endmodule
